/* inc/ffic_pkg.sv */
package ffic_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_CONFIG      = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ERR_CONFIG  = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_ERR_STATUS  = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS      = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_CMD_PARAM   = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 4'h6;

  // flash_config bits
  localparam int CFG_CMD_DONE_IE  = 7;
  localparam int CFG_IGNORE_SF    = 4;
  localparam int CFG_FORCE_DF     = 1;
  localparam int CFG_FORCE_SF     = 0;
  localparam logic [DATA_W-1:0] CFG_MASK = 8'h93;

  // error_irq_config / error_status bits
  localparam int ERR_DF = 1;
  localparam int ERR_SF = 0;
  localparam logic [DATA_W-1:0] ERR_MASK = 8'h03;

  // flash_status bits
  localparam int STAT_CMD_DONE = 7;

  // event status / mask bits
  localparam int EV_CMD_DONE = 0;
  localparam int EV_SF       = 1;
  localparam int EV_DF       = 2;
  localparam int EV_W        = 3;
  localparam logic [DATA_W-1:0] EV_MASK = 8'h07;

  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  typedef enum logic [1:0] {
    FFIC_IDLE = 2'b00,
    FFIC_BUSY = 2'b01
  } ffic_cmd_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ffic_bus_t;

  typedef struct packed {
    logic array_read;
    logic real_sf;
    logic real_df;
    logic cmd_finish;
  } ffic_evt_t;

  typedef struct packed {
    logic [DATA_W-1:0] config_r;
    logic [DATA_W-1:0] err_config;
    logic [DATA_W-1:0] err_status;
    logic [DATA_W-1:0] cmd_param;
    logic [DATA_W-1:0] irq_status;
    logic [DATA_W-1:0] irq_mask;
    ffic_cmd_t         cmd_state;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              cmd_irq;
    logic              err_irq;
    logic              launch;
  } ffic_state_t;

endpackage

/* rtl/ffic_fault_gate.sv */
`timescale 1ns/10ps
module ffic_fault_gate
  import ffic_pkg::*;
(
  input  wire logic real_fault,
  input  wire logic force_fault,
  input  wire logic array_read,
  input  wire logic suppress,
  output logic      fault_set
);

  // forced fault on any array read, else only a real one; suppress blocks both
  assign fault_set = array_read && (force_fault || real_fault) && !suppress;

endmodule

/* rtl/ffic_top.sv */
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/10ps
module ffic_top
  import ffic_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              SRST,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  input  wire logic              ARRAY_READ,
  input  wire logic              REAL_SF,
  input  wire logic              REAL_DF,
  input  wire logic              CMD_FINISH,
  output logic [DATA_W-1:0]      RDATA,
  output logic                   IRQ,
  output logic                   CMD_IRQ,
  output logic                   ERR_IRQ,
  output logic                   CMD_LAUNCH
);

  ffic_state_t st;
  ffic_state_t next_st;
  ffic_bus_t   bus;
  ffic_evt_t   evt;
  logic        sf_set;
  logic        df_set;
  logic        cmd_done;
  logic        rd_irq_status;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign evt = '{array_read: ARRAY_READ, real_sf: REAL_SF, real_df: REAL_DF,
                 cmd_finish: CMD_FINISH};
  assign cmd_done = (st.cmd_state == FFIC_IDLE);
  assign rd_irq_status = bus.rd && (bus.addr == ADDR_IRQ_STATUS);

  // single fault: suppressed by ignore bit
  ffic_fault_gate u_sf (
    .real_fault  (evt.real_sf),
    .force_fault (st.config_r[CFG_FORCE_SF]),
    .array_read  (evt.array_read),
    .suppress    (st.config_r[CFG_IGNORE_SF]),
    .fault_set   (sf_set)
  );

  // double fault: never suppressed
  ffic_fault_gate u_df (
    .real_fault  (evt.real_df),
    .force_fault (st.config_r[CFG_FORCE_DF]),
    .array_read  (evt.array_read),
    .suppress    (1'b0),
    .fault_set   (df_set)
  );

  always_comb begin
    next_st        = st;
    next_st.launch = 1'b0;
    next_st.rdata  = ZERO_BYTE;

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        ADDR_CONFIG: begin
          next_st.config_r = bus.wdata & CFG_MASK;
        end
        ADDR_ERR_CONFIG: begin
          next_st.err_config = bus.wdata & ERR_MASK;
        end
        ADDR_ERR_STATUS: begin
          next_st.err_status = st.err_status & ~(bus.wdata & ERR_MASK);
        end
        ADDR_STATUS: begin
          // writing 1 to the done bit launches a command, only when idle
          if (bus.wdata[STAT_CMD_DONE] && cmd_done) begin
            next_st.cmd_state = FFIC_BUSY;
            next_st.launch    = 1'b1;
          end
        end
        ADDR_CMD_PARAM: begin
          if (cmd_done) begin
            next_st.cmd_param = bus.wdata;
          end
        end
        ADDR_IRQ_MASK: begin
          next_st.irq_mask = bus.wdata & EV_MASK;
        end
        default: begin
        end
      endcase
    end

    if (st.cmd_state == FFIC_BUSY && evt.cmd_finish) begin
      next_st.cmd_state = FFIC_IDLE;
    end

    // fault flags, set wins over clear
    if (sf_set) begin
      next_st.err_status[ERR_SF] = 1'b1;
    end
    if (df_set) begin
      next_st.err_status[ERR_DF] = 1'b1;
    end

    // sticky event bits, cleared by reading, set wins
    if (rd_irq_status) begin
      next_st.irq_status = ZERO_BYTE;
    end
    if (st.cmd_state == FFIC_BUSY && evt.cmd_finish) begin
      next_st.irq_status[EV_CMD_DONE] = 1'b1;
    end
    if (sf_set) begin
      next_st.irq_status[EV_SF] = 1'b1;
    end
    if (df_set) begin
      next_st.irq_status[EV_DF] = 1'b1;
    end

    // reads
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CONFIG:     next_st.rdata = st.config_r;
        ADDR_ERR_CONFIG: next_st.rdata = st.err_config;
        ADDR_ERR_STATUS: next_st.rdata = st.err_status;
        ADDR_STATUS:     next_st.rdata[STAT_CMD_DONE] = cmd_done;
        ADDR_CMD_PARAM:  next_st.rdata = st.cmd_param;
        ADDR_IRQ_STATUS: next_st.rdata = st.irq_status;
        ADDR_IRQ_MASK:   next_st.rdata = st.irq_mask;
        default:         next_st.rdata = ZERO_BYTE;
      endcase
    end

    // interrupt requests
    next_st.cmd_irq = next_st.config_r[CFG_CMD_DONE_IE]
                      && (next_st.cmd_state == FFIC_IDLE);
    next_st.err_irq = |(next_st.err_status & next_st.err_config & ERR_MASK);
    next_st.irq     = |(next_st.irq_status & next_st.irq_mask);
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // all outputs come from registers: read data, irqs and the launch pulse
  assign RDATA      = st.rdata;
  assign IRQ        = st.irq;
  assign CMD_IRQ    = st.cmd_irq;
  assign ERR_IRQ    = st.err_irq;
  assign CMD_LAUNCH = st.launch;

  sequence s_cfg_write_zero_force;
    WR && ADDR == ADDR_CONFIG && !WDATA[CFG_FORCE_DF];
  endsequence

  sequence s_cfg_write_zero_single;
    WR && ADDR == ADDR_CONFIG && !WDATA[CFG_FORCE_SF];
  endsequence

  sequence s_launch_idle;
    WR && ADDR == ADDR_STATUS && WDATA[STAT_CMD_DONE] && st.cmd_state == FFIC_IDLE;
  endsequence

  sequence s_launch_busy;
    WR && ADDR == ADDR_STATUS && st.cmd_state == FFIC_BUSY;
  endsequence

  sequence s_finish_busy;
    CMD_FINISH && st.cmd_state == FFIC_BUSY;
  endsequence

  a_cmd_irq_enable: assert property (@(posedge CLK) disable iff (SRST)
    CMD_IRQ == (st.config_r[CFG_CMD_DONE_IE] && st.cmd_state == FFIC_IDLE))
    else $error("command irq does not follow enable and done flag");

  a_ignore_single: assert property (@(posedge CLK) disable iff (SRST)
    st.config_r[CFG_IGNORE_SF] && !(WR && ADDR == ADDR_ERR_STATUS)
    && !st.err_status[ERR_SF] |=> !st.err_status[ERR_SF])
    else $error("single fault reported while ignored");

  a_force_double: assert property (@(posedge CLK) disable iff (SRST)
    ARRAY_READ && st.config_r[CFG_FORCE_DF] |=> st.err_status[ERR_DF])
    else $error("forced double fault not flagged");

  a_force_double_hold: assert property (@(posedge CLK) disable iff (SRST)
    st.config_r[CFG_FORCE_DF] && !(WR && ADDR == ADDR_CONFIG)
    |=> st.config_r[CFG_FORCE_DF])
    else $error("forced double fault bit cleared without write");

  a_force_double_clr: assert property (@(posedge CLK) disable iff (SRST)
    s_cfg_write_zero_force |=> !st.config_r[CFG_FORCE_DF])
    else $error("forced double fault bit not cleared by write");

  a_force_single: assert property (@(posedge CLK) disable iff (SRST)
    ARRAY_READ && st.config_r[CFG_FORCE_SF] && !st.config_r[CFG_IGNORE_SF]
    |=> st.err_status[ERR_SF])
    else $error("forced single fault not flagged");

  a_force_single_hold: assert property (@(posedge CLK) disable iff (SRST)
    st.config_r[CFG_FORCE_SF] && !(WR && ADDR == ADDR_CONFIG)
    |=> st.config_r[CFG_FORCE_SF])
    else $error("forced single fault bit cleared without write");

  a_err_irq_gate: assert property (@(posedge CLK) disable iff (SRST)
    ERR_IRQ == |(st.err_status & st.err_config))
    else $error("error irq not gated by enables");

  a_param_locked: assert property (@(posedge CLK) disable iff (SRST)
    WR && ADDR == ADDR_CMD_PARAM && st.cmd_state == FFIC_BUSY
    |=> st.cmd_param == $past(st.cmd_param))
    else $error("parameter written while command active");

  a_cfg_reserved: assert property (@(posedge CLK) disable iff (SRST)
    RD && ADDR == ADDR_CONFIG |=> (RDATA & ~CFG_MASK) == ZERO_BYTE)
    else $error("reserved config bits read nonzero");

  a_rdata_idle: assert property (@(posedge CLK) disable iff (SRST)
    !RD |=> RDATA == ZERO_BYTE)
    else $error("read data not zero outside a read");

  a_cmd_irq_off: assert property (@(posedge CLK) disable iff (SRST)
    !st.config_r[CFG_CMD_DONE_IE] |-> !CMD_IRQ)
    else $error("command irq raised while disabled");

  a_cmd_irq_busy: assert property (@(posedge CLK) disable iff (SRST)
    st.cmd_state == FFIC_BUSY |-> !CMD_IRQ)
    else $error("command irq raised while command active");

  a_cmd_finish: assert property (@(posedge CLK) disable iff (SRST)
    s_finish_busy |=> st.cmd_state == FFIC_IDLE && st.irq_status[EV_CMD_DONE])
    else $error("command finish not recorded");

  a_ignore_irq: assert property (@(posedge CLK) disable iff (SRST)
    st.config_r[CFG_IGNORE_SF] && !st.irq_status[EV_SF] |=> !st.irq_status[EV_SF])
    else $error("single fault event raised while ignored");

  a_df_not_ignored: assert property (@(posedge CLK) disable iff (SRST)
    ARRAY_READ && REAL_DF && st.config_r[CFG_IGNORE_SF] |=> st.err_status[ERR_DF])
    else $error("double fault suppressed by single fault ignore");

  a_real_double: assert property (@(posedge CLK) disable iff (SRST)
    ARRAY_READ && REAL_DF |=> st.err_status[ERR_DF])
    else $error("real double fault not flagged");

  a_df_irq: assert property (@(posedge CLK) disable iff (SRST)
    ARRAY_READ && st.config_r[CFG_FORCE_DF] && st.err_config[ERR_DF]
    && !(WR && ADDR == ADDR_ERR_CONFIG) |=> ERR_IRQ)
    else $error("forced double fault raised no irq");

  a_df_needs_read: assert property (@(posedge CLK) disable iff (SRST)
    !ARRAY_READ && !st.err_status[ERR_DF] |=> !st.err_status[ERR_DF])
    else $error("double fault flag set without array read");

  a_real_single: assert property (@(posedge CLK) disable iff (SRST)
    ARRAY_READ && REAL_SF && !st.config_r[CFG_IGNORE_SF] |=> st.err_status[ERR_SF])
    else $error("real single fault not flagged");

  a_sf_irq: assert property (@(posedge CLK) disable iff (SRST)
    ARRAY_READ && st.config_r[CFG_FORCE_SF] && !st.config_r[CFG_IGNORE_SF]
    && st.err_config[ERR_SF] && !(WR && ADDR == ADDR_ERR_CONFIG) |=> ERR_IRQ)
    else $error("forced single fault raised no irq");

  a_sf_needs_read: assert property (@(posedge CLK) disable iff (SRST)
    !ARRAY_READ && !st.err_status[ERR_SF] |=> !st.err_status[ERR_SF])
    else $error("single fault flag set without array read");

  a_force_single_clr: assert property (@(posedge CLK) disable iff (SRST)
    s_cfg_write_zero_single |=> !st.config_r[CFG_FORCE_SF])
    else $error("forced single fault bit not cleared by write");

  a_err_cfg_write: assert property (@(posedge CLK) disable iff (SRST)
    WR && ADDR == ADDR_ERR_CONFIG |=> st.err_config == ($past(WDATA) & ERR_MASK))
    else $error("error irq config write not taken");

  a_err_cfg_read: assert property (@(posedge CLK) disable iff (SRST)
    RD && ADDR == ADDR_ERR_CONFIG |=> RDATA == $past(st.err_config))
    else $error("error irq config read back wrong");

  a_err_cfg_unassigned: assert property (@(posedge CLK) disable iff (SRST)
    (st.err_config & ~ERR_MASK) == ZERO_BYTE)
    else $error("unassigned error irq config bits set");

  a_err_irq_off: assert property (@(posedge CLK) disable iff (SRST)
    st.err_config == ZERO_BYTE |-> !ERR_IRQ)
    else $error("error irq raised with all enables clear");

  a_launch_pulse: assert property (@(posedge CLK) disable iff (SRST)
    s_launch_idle |=> CMD_LAUNCH && st.cmd_state == FFIC_BUSY)
    else $error("command not launched while idle");

  a_launch_refused: assert property (@(posedge CLK) disable iff (SRST)
    s_launch_busy |=> !CMD_LAUNCH)
    else $error("command launched while active");

  a_launch_single: assert property (@(posedge CLK) disable iff (SRST)
    CMD_LAUNCH |=> !CMD_LAUNCH)
    else $error("launch pulse longer than one cycle");

  a_busy_holds: assert property (@(posedge CLK) disable iff (SRST)
    st.cmd_state == FFIC_BUSY && !CMD_FINISH |=> st.cmd_state == FFIC_BUSY)
    else $error("command ended without finish");

  a_done_reads_zero: assert property (@(posedge CLK) disable iff (SRST)
    RD && ADDR == ADDR_STATUS && st.cmd_state == FFIC_BUSY |=> RDATA == ZERO_BYTE)
    else $error("done flag reads set while command active");

  a_done_reads_one: assert property (@(posedge CLK) disable iff (SRST)
    RD && ADDR == ADDR_STATUS && st.cmd_state == FFIC_IDLE |=> RDATA[STAT_CMD_DONE])
    else $error("done flag reads clear while idle");

  a_param_write: assert property (@(posedge CLK) disable iff (SRST)
    WR && ADDR == ADDR_CMD_PARAM && st.cmd_state == FFIC_IDLE |=> st.cmd_param == $past(WDATA))
    else $error("parameter write refused while idle");

  a_cfg_write: assert property (@(posedge CLK) disable iff (SRST)
    WR && ADDR == ADDR_CONFIG |=> st.config_r == ($past(WDATA) & CFG_MASK))
    else $error("config write not taken");

  a_cfg_read: assert property (@(posedge CLK) disable iff (SRST)
    RD && ADDR == ADDR_CONFIG |=> RDATA == $past(st.config_r))
    else $error("config read back wrong");

  a_cfg_unassigned: assert property (@(posedge CLK) disable iff (SRST)
    (st.config_r & ~CFG_MASK) == ZERO_BYTE)
    else $error("unassigned config bits set");

  a_reset_config: assert property (@(posedge CLK)
    SRST |=> st.config_r == ZERO_BYTE && st.err_config == ZERO_BYTE)
    else $error("config not cleared by reset");

  a_reset_outputs: assert property (@(posedge CLK)
    SRST |=> RDATA == ZERO_BYTE && !IRQ && !CMD_IRQ && !ERR_IRQ && !CMD_LAUNCH)
    else $error("outputs not cleared by reset");

endmodule

/* test/tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import ffic_pkg::*;
;
  logic              CLK = 1'b0;
  logic              SRST = 1'b1;
  logic [ADDR_W-1:0] ADDR = 4'h0;
  logic [DATA_W-1:0] WDATA = ZERO_BYTE;
  logic              WR = 1'b0;
  logic              RD = 1'b0;
  logic              ARRAY_READ = 1'b0;
  logic              REAL_SF = 1'b0;
  logic              REAL_DF = 1'b0;
  logic              CMD_FINISH = 1'b0;
  logic [DATA_W-1:0] RDATA;
  logic              IRQ;
  logic              CMD_IRQ;
  logic              ERR_IRQ;
  logic              CMD_LAUNCH;
  int                fail_count = 0;
  int                checked = 0;

  ffic_top ffic_top_i (
    .CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .ARRAY_READ(ARRAY_READ), .REAL_SF(REAL_SF), .REAL_DF(REAL_DF),
    .CMD_FINISH(CMD_FINISH), .RDATA(RDATA), .IRQ(IRQ), .CMD_IRQ(CMD_IRQ),
    .ERR_IRQ(ERR_IRQ), .CMD_LAUNCH(CMD_LAUNCH)
  );

  always #4 CLK = ~CLK;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, e);
  endtask

  task automatic ar(input logic s, input logic d);
    @(posedge CLK);
    ARRAY_READ <= 1'b1;
    REAL_SF <= s;
    REAL_DF <= d;
    @(posedge CLK);
    ARRAY_READ <= 1'b0;
    REAL_SF <= 1'b0;
    REAL_DF <= 1'b0;
    #1;
  endtask

  task automatic t_regs();
    rd(ADDR_CONFIG, ZERO_BYTE);
    chk({IRQ, CMD_IRQ, ERR_IRQ, CMD_LAUNCH}, 8'h00);
    wr(ADDR_CONFIG, 8'hFF);
    rd(ADDR_CONFIG, CFG_MASK);
    wr(ADDR_CONFIG, ZERO_BYTE);
    wr(ADDR_ERR_CONFIG, 8'hFF);
    rd(ADDR_ERR_CONFIG, ERR_MASK);
    wr(ADDR_ERR_CONFIG, ZERO_BYTE);
    rd(ADDR_ERR_CONFIG, ZERO_BYTE);
  endtask

  task automatic t_single();
    wr(ADDR_ERR_CONFIG, ERR_MASK);
    wr(ADDR_IRQ_MASK, EV_MASK);
    wr(ADDR_CONFIG, 8'h01);
    ar(1'b0, 1'b0);
    chk({7'h00, ERR_IRQ}, 8'h01);
    chk({7'h00, IRQ}, 8'h01);
    rd(ADDR_ERR_STATUS, 8'h01);
    rd(ADDR_IRQ_STATUS, 8'h02);
    chk({7'h00, IRQ}, 8'h00);
    ar(1'b0, 1'b0);
    rd(ADDR_CONFIG, 8'h01);
    wr(ADDR_IRQ_MASK, ZERO_BYTE);
    ar(1'b0, 1'b0);
    chk({7'h00, IRQ}, 8'h00);
    wr(ADDR_ERR_STATUS, ERR_MASK);
    wr(ADDR_CONFIG, ZERO_BYTE);
    ar(1'b0, 1'b0);
    rd(ADDR_ERR_STATUS, ZERO_BYTE);
    ar(1'b1, 1'b0);
    rd(ADDR_ERR_STATUS, 8'h01);
    wr(ADDR_ERR_STATUS, ERR_MASK);
  endtask

  task automatic t_double();
    wr(ADDR_CONFIG, 8'h02);
    ar(1'b0, 1'b0);
    chk({7'h00, ERR_IRQ}, 8'h01);
    rd(ADDR_ERR_STATUS, 8'h02);
    ar(1'b0, 1'b0);
    rd(ADDR_CONFIG, 8'h02);
    wr(ADDR_ERR_STATUS, ERR_MASK);
    wr(ADDR_CONFIG, ZERO_BYTE);
    ar(1'b0, 1'b1);
    rd(ADDR_ERR_STATUS, 8'h02);
    wr(ADDR_ERR_STATUS, ERR_MASK);
  endtask

  task automatic t_ignore();
    wr(ADDR_CONFIG, 8'h11);
    ar(1'b1, 1'b0);
    chk({7'h00, ERR_IRQ}, 8'h00);
    rd(ADDR_ERR_STATUS, ZERO_BYTE);
    wr(ADDR_CONFIG, 8'h12);
    ar(1'b0, 1'b0);
    rd(ADDR_ERR_STATUS, 8'h02);
    wr(ADDR_ERR_STATUS, ERR_MASK);
    wr(ADDR_ERR_CONFIG, ZERO_BYTE);
    wr(ADDR_CONFIG, 8'h01);
    ar(1'b0, 1'b0);
    chk({7'h00, ERR_IRQ}, 8'h00);
    rd(ADDR_ERR_STATUS, 8'h01);
    wr(ADDR_CONFIG, ZERO_BYTE);
  endtask

  task automatic t_cmd();
    rd(ADDR_IRQ_STATUS, 8'h06);
    wr(ADDR_CONFIG, 8'h80);
    chk({7'h00, CMD_IRQ}, 8'h01);
    rd(ADDR_STATUS, 8'h80);
    wr(ADDR_CMD_PARAM, 8'h5A);
    wr(ADDR_STATUS, 8'h80);
    chk({7'h00, CMD_LAUNCH}, 8'h01);
    chk({7'h00, CMD_IRQ}, 8'h00);
    rd(ADDR_STATUS, ZERO_BYTE);
    wr(ADDR_CMD_PARAM, 8'hA5);
    rd(ADDR_CMD_PARAM, 8'h5A);
    wr(ADDR_STATUS, 8'h80);
    chk({7'h00, CMD_LAUNCH}, 8'h00);
    @(posedge CLK);
    CMD_FINISH <= 1'b1;
    @(posedge CLK);
    CMD_FINISH <= 1'b0;
    #1;
    chk({7'h00, CMD_IRQ}, 8'h01);
    rd(ADDR_STATUS, 8'h80);
    rd(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_CONFIG, ZERO_BYTE);
    chk({7'h00, CMD_IRQ}, 8'h00);
  endtask

  task automatic wrap_up();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge CLK);
    SRST <= 1'b0;
    t_regs();
    t_single();
    t_double();
    t_ignore();
    t_cmd();
    wrap_up();
  end
endmodule
